// >>> acc_conversion_control.sv
// Control, status and result registers of a 10-bit successive-approximation converter.
//
// What this block does
// - Enable bit powers converter; clearing it aborts a running conversion without result.
// - Single-shot: each conversion starts when software writes one to start bit.
// - Free-running: one start write launches first conversion, rest follow automatically.
// - First conversion after enabling takes 25 converter clocks, others take 13.
// - Start bit reads one during conversion, hardware clears it at the end.
// - Writing zero to start bit is ignored.
// - Free-running bit set refreshes results continuously; clearing it ends free running.
// - Done flag sets when conversion finishes; result registers are updated then unless locked.
// - Interrupt request needs flag, interrupt enable and global interrupt enable.
// - Done flag clears when the processor takes the matching interrupt vector.
// - Writing one to done flag clears it; writing zero leaves it.
// - Prescaler codes 000,001 divide by 2; 010..111 divide by 4 to 128.
// - Differential channel selection gives two's complement result, otherwise unsigned.
// - Reading low byte locks results until high byte is read.
// - Right adjust: low byte bits 7:0, high byte bits 1:0 hold 9:8.
// - Left adjust: high byte holds 9:2, low byte bits 7:6 hold 1:0.
// - Control/status register at I/O offset 0x06, all bits reset zero.
// - Left adjust change alters result presentation immediately.
// - Reference and channel changes take effect only after the running conversion.
`timescale 1ns/100ps
`include "acc_map.svh"

module acc_conversion_control
  import acc_pkg::*;
(
  input  wire logic       i_clk,           // System clock, 25 MHz.
  input  wire logic       i_rstn,          // Asynchronous reset, active low.
  input  wire logic [5:0] i_io_addr,       // I/O register address.
  input  wire logic       i_io_wr,         // Write strobe, one cycle.
  input  wire logic       i_io_rd,         // Read strobe, one cycle.
  input  wire logic [7:0] i_io_wdata,      // Write data.
  input  wire logic       i_global_ie,     // Processor global interrupt enable.
  input  wire logic       i_irq_ack,       // Processor takes the done vector.
  input  wire logic [9:0] i_sample,        // Stub analog core sample value.
  output logic      [7:0] o_io_rdata,      // Registered read data.
  output logic            o_irq,           // Conversion-complete request.
  output logic            o_converter_on,  // Analog core powered.
  output logic      [1:0] o_reference_select,  // Reference in use.
  output logic      [4:0] o_channel_gain_select // Channel in use.
);

  // --------------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------------
  acc_state_t state;
  acc_state_t next_state;
  logic [7:0] ctrl;          // Enable, free-run, irq enable and prescale bits.
  logic       done_flag;
  logic [7:0] input_sel;
  logic [9:0] result;
  logic       locked;
  logic       first_pending; // Next conversion is the long initialising one.
  logic       long_conv;
  logic [6:0] presc_cnt;
  logic [4:0] tick_cnt;
  logic [9:0] held_sample;

  // Decode of the 3-bit prescale code to a terminal count; used once, for presc_last.
  function automatic logic [6:0] acc_div_last(input logic [2:0] code);
    logic [7:0] div;
    div = (code < 3'h2) ? 8'h02 : (8'h01 << code);
    return 7'(div - 8'h01);
  endfunction

  // Channel codes 01000 and above pick a differential pair, except the two fixed inputs.
  function automatic logic acc_is_diff(input logic [4:0] chan);
    return (chan >= 5'h08) && (chan < 5'h1E);
  endfunction

  // --------------------------------------------------------------------------
  // Bus decode.
  // --------------------------------------------------------------------------
  wire wr_ctrl   = i_io_wr && (i_io_addr == `ACC_OFS_CTRL_STATUS);
  wire wr_sel    = i_io_wr && (i_io_addr == `ACC_OFS_INPUT_SEL);
  wire rd_low    = i_io_rd && (i_io_addr == `ACC_OFS_RESULT_LOW);
  wire rd_high   = i_io_rd && (i_io_addr == `ACC_OFS_RESULT_HIGH);
  wire enable    = ctrl[`ACC_BIT_ENABLE];
  wire next_en   = wr_ctrl ? i_io_wdata[`ACC_BIT_ENABLE] : enable;
  // A zero in the start bit is simply not a start.
  wire sw_start  = wr_ctrl && i_io_wdata[`ACC_BIT_START] && next_en;
  wire busy      = (state == ACC_CONV);
  wire [6:0] presc_last = acc_div_last(ctrl[`ACC_PRESCALE_MSB:`ACC_PRESCALE_LSB]);
  wire conv_tick = busy && (presc_cnt >= presc_last);
  wire [4:0] conv_len = long_conv ? `ACC_FIRST_CYCLES : `ACC_NORMAL_CYCLES;
  wire conv_end  = conv_tick && (tick_cnt == 5'(conv_len - 5'h01));
  wire free_run  = ctrl[`ACC_BIT_FREE_RUN];
  wire left_adj  = input_sel[`ACC_BIT_LEFT_ADJUST];
  // Right-adjusted and left-adjusted views are formed on the fly from the held result.
  wire [7:0] view_low  = left_adj ? {result[1:0], 6'h00} : result[7:0];
  wire [7:0] view_high = left_adj ? result[9:2] : {6'h00, result[9:8]};
  wire [7:0] status_rd = {ctrl[7], busy, ctrl[5], done_flag, ctrl[3:0]};
  // Two's complement comes from the core for differential pairs; sign-fold unsigned.
  wire [9:0] coded = acc_is_diff(o_channel_gain_select) ? held_sample
                                                        : {1'b0, held_sample[9:1]};
  wire [7:0] next_rdata = (i_io_addr == `ACC_OFS_RESULT_LOW)  ? view_low  :
                          (i_io_addr == `ACC_OFS_RESULT_HIGH) ? view_high :
                          (i_io_addr == `ACC_OFS_CTRL_STATUS) ? status_rd :
                          (i_io_addr == `ACC_OFS_INPUT_SEL)   ? input_sel : 8'h00;

  // --------------------------------------------------------------------------
  // Sequencer.
  // --------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ACC_IDLE: begin
        if (sw_start) begin
          next_state = ACC_CONV;
        end
      end
      ACC_CONV: begin
        if (!next_en) begin
          next_state = ACC_IDLE;
        end else if (conv_end) begin
          next_state = ACC_DONE;
        end
      end
      ACC_DONE: begin
        if (!next_en) begin
          next_state = ACC_IDLE;
        end else if (free_run || sw_start) begin
          next_state = ACC_CONV;
        end else begin
          next_state = ACC_IDLE;
        end
      end
      default: next_state = ACC_IDLE;
    endcase
  end

  // State and control register; start bit is never stored, it mirrors busy.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ACC_IDLE;
      ctrl  <= `ACC_RESET_BYTE;
    end else begin
      state <= next_state;
      if (wr_ctrl) begin
        ctrl <= {i_io_wdata[7], 1'b0, i_io_wdata[5], 1'b0, i_io_wdata[3:0]};
      end
    end
  end

  // Prescaler and converter-clock counter restart with each conversion.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      presc_cnt <= 7'h00;
      tick_cnt  <= 5'h00;
    end else if (!busy || next_state != ACC_CONV) begin
      presc_cnt <= 7'h00;
      tick_cnt  <= 5'h00;
    end else if (conv_tick) begin
      presc_cnt <= 7'h00;
      tick_cnt  <= 5'(tick_cnt + 5'h01);
    end else begin
      presc_cnt <= 7'(presc_cnt + 7'h01);
    end
  end

  // The first conversion after enabling is long; a disable rearms that.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      first_pending <= 1'b1;
      long_conv     <= 1'b0;
    end else begin
      if (!next_en) begin
        first_pending <= 1'b1;
      end else if (next_state == ACC_CONV && state != ACC_CONV) begin
        first_pending <= 1'b0;
        long_conv     <= first_pending;
      end
    end
  end

  // Input selection applied to the core only between conversions.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      input_sel             <= `ACC_RESET_BYTE;
      o_reference_select    <= 2'h0;
      o_channel_gain_select <= 5'h00;
    end else begin
      if (wr_sel) begin
        input_sel <= i_io_wdata;
      end
      if (!busy) begin
        o_reference_select    <= input_sel[`ACC_REF_MSB:`ACC_REF_LSB];
        o_channel_gain_select <= input_sel[`ACC_CHAN_MSB:`ACC_CHAN_LSB];
      end
    end
  end

  // Stub core holds its sample at the last converter clock; result lands one cycle on.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      held_sample <= 10'h000;
      result      <= 10'h000;
      locked      <= 1'b0;
    end else begin
      if (conv_end && next_en) begin
        held_sample <= i_sample;
      end
      // A locked result drops the new value, but the flag still sets.
      if (state == ACC_DONE && !locked) begin
        result <= coded;
      end
      if (rd_low) begin
        locked <= 1'b1;
      end else if (rd_high) begin
        locked <= 1'b0;
      end
    end
  end

  // Done flag: hardware set wins over vector or write-one clear.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      done_flag <= 1'b0;
    end else if (state == ACC_DONE) begin
      done_flag <= 1'b1;
    end else if (i_irq_ack || (wr_ctrl && i_io_wdata[`ACC_BIT_DONE_FLAG])) begin
      done_flag <= 1'b0;
    end
  end

  // Registered outputs.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_io_rdata     <= 8'h00;
      o_irq          <= 1'b0;
      o_converter_on <= 1'b0;
    end else begin
      o_io_rdata     <= next_rdata;
      o_irq          <= done_flag && ctrl[`ACC_BIT_IRQ_ENABLE] && i_global_ie;
      o_converter_on <= enable;
    end
  end

endmodule // acc_conversion_control

// >>> acc_map.svh
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
// ----------------------------------------------------------------------------
// Register offsets (I/O space).
// ----------------------------------------------------------------------------
`define ACC_OFS_RESULT_LOW   6'h04
`define ACC_OFS_RESULT_HIGH  6'h05
`define ACC_OFS_CTRL_STATUS  6'h06
`define ACC_OFS_INPUT_SEL    6'h07
// ----------------------------------------------------------------------------
// Control/status field positions.
// ----------------------------------------------------------------------------
`define ACC_BIT_ENABLE       7
`define ACC_BIT_START        6
`define ACC_BIT_FREE_RUN     5
`define ACC_BIT_DONE_FLAG    4
`define ACC_BIT_IRQ_ENABLE   3
`define ACC_PRESCALE_MSB     2
`define ACC_PRESCALE_LSB     0
// ----------------------------------------------------------------------------
// Input select field positions.
// ----------------------------------------------------------------------------
`define ACC_REF_MSB          7
`define ACC_REF_LSB          6
`define ACC_BIT_LEFT_ADJUST  5
`define ACC_CHAN_MSB         4
`define ACC_CHAN_LSB         0
// ----------------------------------------------------------------------------
// Reset values and timing counts.
// ----------------------------------------------------------------------------
`define ACC_RESET_BYTE       8'h00
`define ACC_FIRST_CYCLES     5'h19
`define ACC_NORMAL_CYCLES    5'h0D
`endif

// >>> acc_pkg.sv
// Types shared by the converter control.
package acc_pkg;
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_CONV = 3'b010,
    ACC_DONE = 3'b100
  } acc_state_t;
endpackage

// >>> acc_conversion_control_sva.sv
// Port-level assertions for the converter control.
`timescale 1ns/100ps
module acc_conversion_control_sva (
  input wire logic       i_clk,                 // Clock.
  input wire logic       i_rstn,                // Reset, active low.
  input wire logic [5:0] i_io_addr,             // Address.
  input wire logic       i_io_wr,               // Write strobe.
  input wire logic       i_io_rd,               // Read strobe.
  input wire logic [7:0] i_io_wdata,            // Write data.
  input wire logic       i_global_ie,           // Global enable.
  input wire logic       i_irq_ack,             // Vector taken.
  input wire logic [9:0] i_sample,              // Core sample.
  input wire logic [7:0] o_io_rdata,            // Read data.
  input wire logic       o_irq,                 // Request.
  input wire logic       o_converter_on,        // Core powered.
  input wire logic [1:0] o_reference_select,    // Reference.
  input wire logic [4:0] o_channel_gain_select  // Channel.
);
  logic ladj;
  wire  wr06 = i_io_wr && (i_io_addr == 6'h06);
  // Shadow of the left-adjust bit, so the result layout can be judged from the ports.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) ladj <= 1'b0;
    else if (i_io_wr && (i_io_addr == 6'h07)) ladj <= i_io_wdata[5];
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_irq_global_gate: assert property (o_irq |-> $past(i_global_ie)) else $error("irq w/o ie");
  a_enable_copy: assert property (wr06 ##1 !wr06 |=> o_converter_on == $past(i_io_wdata[7], 2))
    else $error("enable not followed");
  a_unmapped_zero: assert property ((i_io_addr < 6'h04 || i_io_addr > 6'h07) |=> o_io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_clear: assert property ($rose(i_rstn) |-> o_io_rdata == 8'h00 && !o_irq && !o_converter_on)
    else $error("reset values wrong");
  a_ack_clear: assert property (i_irq_ack |-> ##2 !o_irq) else $error("ack kept irq");
  a_flag_w1c: assert property (wr06 && (i_io_wdata[4] || !i_io_wdata[3]) |-> ##2 !o_irq)
    else $error("clear kept irq");
  a_sel_idle_follow: assert property (i_io_wr && i_io_addr == 6'h07 && !o_converter_on ##1 !i_io_wr
    |=> o_reference_select == $past(i_io_wdata[7:6], 2) && o_channel_gain_select == $past(i_io_wdata[4:0], 2))
    else $error("select not followed");
  a_high_right: assert property (i_io_addr == 6'h05 && !ladj && !i_io_wr |=> o_io_rdata[7:2] == 6'h00)
    else $error("high byte upper bits set");
  a_low_left: assert property (i_io_addr == 6'h04 && ladj && !i_io_wr |=> o_io_rdata[5:0] == 6'h00)
    else $error("low byte lower bits set");
  c_irq: cover property (o_irq);
  c_ack: cover property (i_irq_ack ##2 !o_irq);
  c_left_low: cover property (i_io_addr == 6'h04 && ladj);
endmodule // acc_conversion_control_sva
bind acc_conversion_control acc_conversion_control_sva u_sva (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
  .i_global_ie(i_global_ie), .i_irq_ack(i_irq_ack), .i_sample(i_sample), .o_io_rdata(o_io_rdata),
  .o_irq(o_irq), .o_converter_on(o_converter_on), .o_reference_select(o_reference_select),
  .o_channel_gain_select(o_channel_gain_select));

// >>> acc_cpu_model.sv
// Processor-side model that performs I/O register accesses.
`timescale 1ns/100ps
module acc_cpu_model (
  input  wire logic       i_clk,      // System clock.
  input  wire logic [7:0] i_io_rdata, // Read data from the block.
  output logic      [5:0] o_io_addr,  // Address.
  output logic            o_io_wr,    // Write strobe.
  output logic            o_io_rd,    // Read strobe.
  output logic      [7:0] o_io_wdata  // Write data.
);
  // The bus parks on an unmapped address; a write leaves inverted data behind, so stale values never pass.
  initial begin
    o_io_addr = 6'h3F;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_wdata = 8'h00;
  end
  // Whole-byte writes only; no read-modify-write of the control register.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_io_addr = a;
    o_io_wdata = d;
    o_io_wr = 1'b1;
    @(negedge i_clk);
    o_io_wr = 1'b0;
    o_io_wdata = ~d;
    o_io_addr = 6'h3F;
  endtask
  // One read; data is taken half a cycle after the address was sampled.
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_io_addr = a;
    o_io_rd = 1'b1;
    @(negedge i_clk);
    o_io_rd = 1'b0;
    d = i_io_rdata;
    o_io_addr = 6'h3F;
  endtask
endmodule // acc_cpu_model

// >>> acc_conversion_control_test.sv
// Self-checking testbench for the converter control.
`timescale 1ns/100ps
module acc_conversion_control_test;
  logic clk = 1'b0, rstn = 1'b0, gie = 1'b1, ack = 1'b0, wr, rd, irq, on;
  logic [9:0] smp = 10'h2A5;
  logic [5:0] addr;
  logic [7:0] wd, rdat, v;
  logic [1:0] reference_select;
  logic [4:0] chan;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n;
  // Every mapped register plus one unmapped address, all zero out of reset.
  logic [5:0] n_addr [5] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h3F};
  acc_conversion_control i_dut (.i_clk(clk), .i_rstn(rstn), .i_io_addr(addr), .i_io_wr(wr),
    .i_io_rd(rd), .i_io_wdata(wd), .i_global_ie(gie), .i_irq_ack(ack), .i_sample(smp),
    .o_io_rdata(rdat), .o_irq(irq), .o_converter_on(on), .o_reference_select(reference_select),
    .o_channel_gain_select(chan));
  acc_cpu_model u_cpu (.i_clk(clk), .i_io_rdata(rdat), .o_io_addr(addr), .o_io_wr(wr),
    .o_io_rd(rd), .o_io_wdata(wd));
  initial begin
    forever #20 clk = ~clk;
  end
  // A hang is cut short well beyond the longest expected run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    u_cpu.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Single shot: long first conversion, short second, flag, request, clear paths.
  task automatic t_single();
    u_cpu.wr(6'h06, 8'hC8);
    rchk(6'h06, 8'hC8);
    repeat (42) @(negedge clk);
    rchk(6'h06, 8'hC8);
    repeat (8) @(negedge clk);
    rchk(6'h06, 8'h98);
    rchk(6'h04, 8'h52);
    rchk(6'h05, 8'h01);
    chk("irq", 8'h01, {7'h00, irq});
    gie = 1'b0;
    repeat (2) @(negedge clk);
    chk("irq gated", 8'h00, {7'h00, irq});
    gie = 1'b1;
    u_cpu.wr(6'h06, 8'hD8);
    rchk(6'h06, 8'hC8);
    repeat (16) @(negedge clk);
    rchk(6'h06, 8'hC8);
    repeat (8) @(negedge clk);
    rchk(6'h06, 8'h98);
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    rchk(6'h06, 8'h88);
  endtask
  // Every prescaler code; conversion time is thirteen converter clocks.
  task automatic t_prescale();
    for (int c = 0; c < 8; c++) begin
      u_cpu.wr(6'h06, 8'hD0 | 8'(c));
      n = 0;
      do begin
        u_cpu.rd(6'h06, v);
        n += 2;
      end while (v[4] !== 1'b1 && n < 4000);
      chk("conv time", 8'h01, {7'h00, (n >= 13 * ((c < 2) ? 2 : (1 << c))) &&
        (n <= 13 * ((c < 2) ? 2 : (1 << c)) + 6)});
    end
  endtask
  // Free running, differential left-adjusted result, low-first lock, live re-adjust.
  task automatic t_lock();
    u_cpu.wr(6'h06, 8'h00);
    u_cpu.wr(6'h07, 8'hF0);
    // The selection reaches the core outputs one clock after the register takes it.
    @(negedge clk);
    chk("channel", 8'h10, {3'h0, chan});
    chk("reference", 8'h03, {6'h00, reference_select});
    u_cpu.wr(6'h06, 8'hE0);
    repeat (60) @(negedge clk);
    rchk(6'h04, 8'h40);
    smp = 10'h155;
    repeat (60) @(negedge clk);
    rchk(6'h05, 8'hA9);
    repeat (40) @(negedge clk);
    rchk(6'h04, 8'h40);
    rchk(6'h05, 8'h55);
    u_cpu.wr(6'h07, 8'h10);
    rchk(6'h05, 8'h01);
    u_cpu.wr(6'h06, 8'h90);
    repeat (40) @(negedge clk);
    u_cpu.wr(6'h06, 8'h90);
    repeat (40) @(negedge clk);
    rchk(6'h06, 8'h80);
  endtask
  // Zero start write is ignored; disabling aborts without flag.
  task automatic t_abort();
    u_cpu.wr(6'h06, 8'hC0);
    u_cpu.wr(6'h06, 8'h80);
    rchk(6'h06, 8'hC0);
    u_cpu.wr(6'h06, 8'h00);
    repeat (60) @(negedge clk);
    rchk(6'h06, 8'h00);
    chk("on", 8'h00, {7'h00, on});
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    foreach (n_addr[i]) rchk(n_addr[i], 8'h00);
    t_single();
    t_prescale();
    t_lock();
    t_abort();
    stop_test();
  end
endmodule // acc_conversion_control_test
